// ===== design/pid_defs.svh
`ifndef PID_DEFS_SVH
`define PID_DEFS_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define PID_CMD_MAKER_ID     8'h99
`define PID_CMD_MODEL        8'h9a
`define PID_CMD_SUPP_REV     8'h9b
`define PID_CMD_SERIAL       8'h9e
`define PID_CMD_PART_ID      8'had
`define PID_CMD_SIL_REV      8'hae

// ----------------------------------------------------------------------
// payload lengths and field positions
// ----------------------------------------------------------------------
`define PID_LEN_STORE        8'h03
`define PID_LEN_PART_ID      8'h06
`define PID_LEN_SIL_REV      8'h02
`define PID_CML_IVC_BIT      7
`define PID_STATUS_CML_BIT   1
`define PID_REV_MAJOR_LSB    12
`define PID_REV_MINOR_LSB    8

// ----------------------------------------------------------------------
// reset values (stores load from nvm after reset)
// ----------------------------------------------------------------------
`define PID_STORE_RST        24'h000000
`define PID_CSUM_RST         8'h00

`endif

// ===== design/pid_pkg.sv
package pid_pkg;
    // host-side request from the pmbus transaction layer
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  cmd;
        logic [7:0]  len;
        logic [47:0] data;
    } pid_req_t;

    // answer back to the transaction layer
    typedef struct packed {
        logic        done;
        logic        ack;
        logic [7:0]  len;
        logic [47:0] data;
    } pid_rsp_t;

    typedef enum logic [1:0] {
        PID_IDLE,
        PID_ANSWER,
        PID_NVM
    } pid_state_t;
endpackage

// ===== design/pid_fault_flags.sv
`timescale 1ns/1ps
`include "pid_defs.svh"
module pid_fault_flags
    import pid_pkg::*;
(
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // events and clears
    input  wire logic       i_ivc_set,
    input  wire logic       i_clear,
    // flags
    output logic [7:0]      o_status_cml,
    output logic [7:0]      o_status_byte,
    output logic            o_alert_n
);
    typedef struct packed {
        logic [7:0] cml;
        logic       alert;
    } pid_flag_st_t;

    pid_flag_st_t s_q, s_d;

    // ------------------------------------------------------------------
    // sticky flags, set beats clear
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (i_clear) begin
            s_d.cml   = 8'h00;
            s_d.alert = 1'b0;
        end
        if (i_ivc_set) begin
            s_d.cml[`PID_CML_IVC_BIT] = 1'b1; // [R13]
            s_d.alert                 = 1'b1; // [R14]
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_status_cml  = s_q.cml;
    // summary bit follows any comm flag
    assign o_status_byte = {6'h00, |s_q.cml, 1'b0}; // [R12]
    assign o_alert_n     = ~s_q.alert;
endmodule

// ===== design/pid_checksum.sv
`timescale 1ns/1ps
`include "pid_defs.svh"
module pid_checksum
    import pid_pkg::*;
(
    // stored image
    input  wire logic [23:0] i_maker,
    input  wire logic [23:0] i_model,
    input  wire logic [23:0] i_rev,
    input  wire logic [23:0] i_serial,
    // sum
    output logic [7:0]       o_sum
);
    // ------------------------------------------------------------------
    // byte sum over the whole image, serial included
    // ------------------------------------------------------------------
    function automatic logic [7:0] bsum(input logic [23:0] v);
        bsum = v[7:0] + v[15:8] + v[23:16];
    endfunction

    assign o_sum = bsum(i_maker) + bsum(i_model) + bsum(i_rev)
                 + bsum(i_serial); // [R05]
endmodule

// ===== design/pid_identity_regs.sv
`timescale 1ns/1ps
`include "pid_defs.svh"
// Operation
// (R01) maker id command keeps 24 writable nonvolatile bits, reads last written value
// (R02) command 9ah holds 24-bit writable model information
// (R03) command 9bh holds 24-bit writable supplier revision information
// (R04) command 9eh holds 24-bit writable serial number
// (R05) serial number is part of the checksummed nonvolatile image
// (R06) model, revision, serial move by block transfers of exactly three bytes
// (R07) stores are single unphased values, each backed by eeprom
// (R08) command adh is block read only, six-byte identifier
// (R09) identifier byte 0 in bits 7:0 up to byte 5 in 47:40
// (R10) command aeh is block read only, two-byte revision
// (R11) revision read-only: major 15:12, minor 11:8, sub-minor low byte
// (R12) write to read-only command sets comm fault summary in status byte
// (R13) that fault also sets invalid-command bit 7 of comm status
// (R14) then the host is alerted
// (R15) a rejected write leaves identifier and revision unchanged
module pid_identity_regs
    import pid_pkg::*;
#(
    parameter logic [47:0] PART_ID = 48'h0000_0000_0000, // arbitrary value
    parameter logic [3:0]  REV_MAJ = 4'h1,
    parameter logic [3:0]  REV_MIN = 4'h0,
    parameter logic [7:0]  REV_SUB = 8'h00
)(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // command port from the pmbus transaction layer
    input  wire pid_req_t    i_req,
    output pid_rsp_t         o_rsp,
    // eeprom backing store
    input  wire logic        i_nvm_load,
    input  wire logic [95:0] i_nvm_image,
    output logic             o_nvm_wr,
    output logic [95:0]      o_nvm_image,
    // checksum and fault reporting
    input  wire logic        i_fault_clear,
    output logic [7:0]       o_csum,
    output logic [7:0]       o_status_cml,
    output logic [7:0]       o_status_byte,
    output logic             o_alert_n
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pid_state_t  st;
        logic [23:0] maker;
        logic [23:0] model;
        logic [23:0] rev;
        logic [23:0] serial;
        pid_rsp_t    rsp;
        logic        nvm_wr;
        logic        ivc;
        logic [7:0]  csum;
        logic [7:0]  cml;
        logic [7:0]  sbyte;
        logic        alert_n;
    } pid_st_t;

    pid_st_t     s_q, s_d;
    logic [7:0]  sum_w;
    logic [7:0]  cml_w;
    logic [7:0]  sbyte_w;
    logic        alert_n_w;
    logic [15:0] sil_rev;

    // silicon revision fields packed at fixed positions
    assign sil_rev = {REV_MAJ, REV_MIN, REV_SUB}; // [R11]

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic is_store(input logic [7:0] c);
        is_store = (c == `PID_CMD_MAKER_ID) || (c == `PID_CMD_MODEL)
                || (c == `PID_CMD_SUPP_REV) || (c == `PID_CMD_SERIAL);
    endfunction

    function automatic logic is_ro(input logic [7:0] c);
        is_ro = (c == `PID_CMD_PART_ID) || (c == `PID_CMD_SIL_REV);
    endfunction

    pid_checksum u_csum (
        .i_maker  (s_q.maker),
        .i_model  (s_q.model),
        .i_rev    (s_q.rev),
        .i_serial (s_q.serial),
        .o_sum    (sum_w)
    );

    pid_fault_flags u_flags (
        .i_core_clk    (i_core_clk),
        .i_rst         (i_rst),
        .i_ivc_set     (s_q.ivc),
        .i_clear       (i_fault_clear),
        .o_status_cml  (cml_w),
        .o_status_byte (sbyte_w),
        .o_alert_n     (alert_n_w)
    );

    // ------------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.rsp.done = 1'b0;
        s_d.nvm_wr   = 1'b0;
        s_d.ivc      = 1'b0;
        s_d.csum     = sum_w;
        s_d.cml      = cml_w;
        s_d.sbyte    = sbyte_w;
        s_d.alert_n  = alert_n_w;
        case (s_q.st)
            PID_IDLE: begin
                if (i_nvm_load) begin
                    // eeprom image restores every store
                    {s_d.maker, s_d.model, s_d.rev, s_d.serial} = i_nvm_image; // [R07]
                end else if (i_req.wr) begin
                    s_d.st       = PID_ANSWER;
                    s_d.rsp.ack  = 1'b0;
                    s_d.rsp.len  = 8'h00;
                    s_d.rsp.data = '0;
                    if (is_ro(i_req.cmd)) begin
                        // stored values untouched on a rejected write
                        s_d.ivc = 1'b1; // [R12] [R15] [R08] [R10]
                    end else if (is_store(i_req.cmd) && i_req.len == `PID_LEN_STORE) begin
                        s_d.rsp.ack = 1'b1; // [R06]
                        s_d.st      = PID_NVM;
                        if (i_req.cmd == `PID_CMD_MAKER_ID) begin
                            s_d.maker = i_req.data[23:0]; // [R01]
                        end else if (i_req.cmd == `PID_CMD_MODEL) begin
                            s_d.model = i_req.data[23:0]; // [R02]
                        end else if (i_req.cmd == `PID_CMD_SUPP_REV) begin
                            s_d.rev = i_req.data[23:0]; // [R03]
                        end else begin
                            s_d.serial = i_req.data[23:0]; // [R04]
                        end
                    end
                end else if (i_req.rd) begin
                    s_d.st       = PID_ANSWER;
                    s_d.rsp.ack  = 1'b1;
                    s_d.rsp.len  = `PID_LEN_STORE;
                    s_d.rsp.data = '0;
                    if (i_req.cmd == `PID_CMD_MAKER_ID) begin
                        s_d.rsp.data[23:0] = s_q.maker; // [R01]
                    end else if (i_req.cmd == `PID_CMD_MODEL) begin
                        s_d.rsp.data[23:0] = s_q.model; // [R02]
                    end else if (i_req.cmd == `PID_CMD_SUPP_REV) begin
                        s_d.rsp.data[23:0] = s_q.rev; // [R03]
                    end else if (i_req.cmd == `PID_CMD_SERIAL) begin
                        s_d.rsp.data[23:0] = s_q.serial; // [R04]
                    end else if (i_req.cmd == `PID_CMD_PART_ID) begin
                        s_d.rsp.len  = `PID_LEN_PART_ID;
                        s_d.rsp.data = PART_ID; // [R08] [R09]
                    end else if (i_req.cmd == `PID_CMD_SIL_REV) begin
                        s_d.rsp.len        = `PID_LEN_SIL_REV;
                        s_d.rsp.data[15:0] = sil_rev; // [R10]
                    end else begin
                        // not ours: leave for other command decoders
                        s_d.rsp.ack = 1'b0;
                        s_d.rsp.len = 8'h00;
                    end
                end
            end
            PID_NVM: begin
                // one-cycle write strobe of the whole image to eeprom
                s_d.nvm_wr = 1'b1; // [R07]
                s_d.st     = PID_ANSWER;
            end
            PID_ANSWER: begin
                s_d.rsp.done = 1'b1;
                s_d.st       = PID_IDLE;
            end
            default: begin
                s_d.st = PID_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q         <= '0;
            s_q.st      <= PID_IDLE;
            s_q.maker   <= `PID_STORE_RST;
            s_q.model   <= `PID_STORE_RST;
            s_q.rev     <= `PID_STORE_RST;
            s_q.serial  <= `PID_STORE_RST;
            s_q.csum    <= `PID_CSUM_RST;
            s_q.alert_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------------
    assign o_rsp         = s_q.rsp;
    assign o_nvm_wr      = s_q.nvm_wr;
    assign o_nvm_image   = {s_q.maker, s_q.model, s_q.rev, s_q.serial};
    assign o_csum        = s_q.csum;
    assign o_status_cml  = s_q.cml;
    assign o_status_byte = s_q.sbyte;
    assign o_alert_n     = s_q.alert_n;
endmodule

// ===== verif/pid_identity_checker.sv
`timescale 1ns/1ps
`include "pid_defs.svh"
module pid_identity_checker
    import pid_pkg::*;
#(
    parameter logic [47:0] PART_ID = 48'h0,
    parameter logic [3:0]  REV_MAJ = 4'h0,
    parameter logic [3:0]  REV_MIN = 4'h0,
    parameter logic [7:0]  REV_SUB = 8'h00
)(
    // watched ports
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire pid_req_t    i_req,
    input wire pid_rsp_t    o_rsp,
    input wire logic        i_nvm_load,
    input wire logic [95:0] i_nvm_image,
    input wire logic        o_nvm_wr,
    input wire logic [95:0] o_nvm_image,
    input wire logic        i_fault_clear,
    input wire logic [7:0]  o_csum,
    input wire logic [7:0]  o_status_cml,
    input wire logic [7:0]  o_status_byte,
    input wire logic        o_alert_n
);
    // ----------------
    // helpers
    // ----------------
    logic       ro_wr;
    logic       st_wr;
    logic [7:0] img_sum;
    assign ro_wr = i_req.wr && i_req.cmd inside {`PID_CMD_PART_ID, `PID_CMD_SIL_REV};
    assign st_wr = i_req.wr && i_req.cmd inside {`PID_CMD_MAKER_ID, `PID_CMD_MODEL,
                                                 `PID_CMD_SUPP_REV, `PID_CMD_SERIAL};
    // byte sum of the visible image, summed independently of the design
    always_comb begin
        img_sum = 8'h00;
        for (int k = 0; k < 12; k++) img_sum += o_nvm_image[8*k +: 8];
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // ----------------
    // properties
    // ----------------
    chk_part_read: assert property (i_req.rd && !i_req.wr && i_req.cmd == `PID_CMD_PART_ID
        |=> o_rsp.ack && o_rsp.len == `PID_LEN_PART_ID && o_rsp.data == PART_ID ##1 o_rsp.done)
        else $error("part identifier read wrong");
    chk_rev_read: assert property (i_req.rd && !i_req.wr && i_req.cmd == `PID_CMD_SIL_REV
        |=> o_rsp.ack && o_rsp.len == `PID_LEN_SIL_REV
            && o_rsp.data[15:0] == {REV_MAJ, REV_MIN, REV_SUB})
        else $error("silicon revision read wrong");
    chk_ro_flag: assert property (ro_wr |=> !o_rsp.ack ##2
        o_status_cml[`PID_CML_IVC_BIT] && o_status_byte[`PID_STATUS_CML_BIT])
        else $error("invalid command not flagged");
    chk_ro_alert: assert property (ro_wr |-> ##[2:3] !o_alert_n)
        else $error("alert not raised");
    chk_ro_kept: assert property (ro_wr |-> ##1 (!o_nvm_wr && $stable(o_nvm_image))[*3])
        else $error("rejected write changed stores");
    chk_store_wr: assert property (st_wr && i_req.len == `PID_LEN_STORE
        |=> o_rsp.ack ##1 o_nvm_wr ##1 o_rsp.done)
        else $error("store write not committed");
    chk_serial_img: assert property (st_wr && i_req.cmd == `PID_CMD_SERIAL
        && i_req.len == `PID_LEN_STORE |-> ##2 o_nvm_image[23:0] == $past(i_req.data[23:0], 2))
        else $error("serial store wrong");
    chk_bad_len: assert property (st_wr && i_req.len != `PID_LEN_STORE
        |=> !o_rsp.ack ##1 !o_nvm_wr)
        else $error("short store write accepted");
    chk_csum_sum: assert property ($stable(o_nvm_image)[*3] |-> o_csum == img_sum)
        else $error("checksum mismatch");
endmodule

bind pid_identity_regs pid_identity_checker #(.PART_ID(PART_ID), .REV_MAJ(REV_MAJ),
    .REV_MIN(REV_MIN), .REV_SUB(REV_SUB)) u_pid_identity_checker (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_req(i_req), .o_rsp(o_rsp), .i_nvm_load(i_nvm_load),
    .i_nvm_image(i_nvm_image), .o_nvm_wr(o_nvm_wr), .o_nvm_image(o_nvm_image),
    .i_fault_clear(i_fault_clear), .o_csum(o_csum), .o_status_cml(o_status_cml),
    .o_status_byte(o_status_byte), .o_alert_n(o_alert_n));

// ===== verif/pid_host.sv
`timescale 1ns/1ps
module pid_host
    import pid_pkg::*;
(
    // clock and answer
    input  wire logic     i_core_clk,
    input  wire pid_rsp_t i_rsp,
    // request
    output pid_req_t      o_req
);
    initial o_req = '0;
    // one block transfer; the bench picks len, so rule-breaking writes are its choice
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] len,
                        input logic [47:0] data, output pid_rsp_t rsp);
        int n;
        n = 0;
        @(posedge i_core_clk);
        o_req <= '{wr: wr, rd: !wr, cmd: cmd, len: len, data: data};
        @(posedge i_core_clk);
        // payload lines go stale, not held at the last value
        o_req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, len: ~len, data: ~data};
        do begin
            @(negedge i_core_clk);
            n++;
        end while (i_rsp.done !== 1'b1 && n < 20);
        rsp = i_rsp;
    endtask
endmodule

// ===== verif/pid_identity_regs_test.sv
`timescale 1ns/1ps
`include "pid_defs.svh"
module pid_identity_regs_test
    import pid_pkg::*;
;
    localparam logic [47:0] PART_ID = 48'h5a3c_e1f0_9d27; // arbitrary value
    logic        i_core_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_nvm_load = 1'b0;
    logic [95:0] i_nvm_image = 96'h0;
    logic        i_fault_clear = 1'b0;
    pid_req_t    req;
    pid_rsp_t    rsp;
    pid_rsp_t    got;
    logic        nvm_wr;
    logic        alert_n;
    logic [95:0] nvm_image;
    logic [95:0] img;
    logic [7:0]  csum;
    logic [7:0]  cml;
    logic [7:0]  stat;
    logic [7:0]  cmds [4] = '{`PID_CMD_MAKER_ID, `PID_CMD_MODEL, `PID_CMD_SUPP_REV,
                              `PID_CMD_SERIAL};
    logic [7:0]  ro_cmd [2] = '{`PID_CMD_PART_ID, `PID_CMD_SIL_REV};
    logic [47:0] ro_val [2] = '{PART_ID, 48'h3_5a7};
    int          n_fail = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    pid_identity_regs #(.PART_ID(PART_ID), .REV_MAJ(4'h3), .REV_MIN(4'h5), .REV_SUB(8'ha7))
    u_pid_identity_regs (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req), .o_rsp(rsp),
        .i_nvm_load(i_nvm_load), .i_nvm_image(i_nvm_image), .o_nvm_wr(nvm_wr),
        .o_nvm_image(nvm_image), .i_fault_clear(i_fault_clear), .o_csum(csum),
        .o_status_cml(cml), .o_status_byte(stat), .o_alert_n(alert_n));
    pid_host u_pid_host (.i_core_clk(i_core_clk), .i_rsp(rsp), .o_req(req));

    // ----------------
    // tasks
    // ----------------
    task automatic check(input logic [95:0] g, input logic [95:0] e);
        num_checks++;
        if (g !== e) begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            n_fail++;
        end
    endtask
    // read all four stores and the checksum against img
    task automatic rd_stores();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 12; i++) s += img[8*i +: 8];
        for (int i = 0; i < 4; i++) begin
            u_pid_host.xfer(1'b0, cmds[i], 8'h00, 48'h0, got);
            check({got.ack, got.len, got.data[23:0]}, {1'b1, 8'h03, img[(3-i)*24 +: 24]});
        end
        check({nvm_image, csum}, {img, s});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard, far above the under a hundred cycles the tests need
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    // ----------------
    // tests
    // ----------------
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        check({csum, cml, stat, alert_n}, 25'h1);
        img = 96'h1a2b3c_4d5e6f_718293_a4b5c6;
        @(posedge i_core_clk);
        i_nvm_image <= img;
        i_nvm_load <= 1'b1;
        @(posedge i_core_clk);
        i_nvm_load <= 1'b0;
        rd_stores();
        $display("eeprom load test done");
        img = 96'hc3d2e1_f00f1e_2d3c4b_5a6978;
        for (int i = 0; i < 4; i++) begin
            u_pid_host.xfer(1'b1, cmds[i], 8'h03, {24'h0, img[(3-i)*24 +: 24]}, got);
            check(got.ack, 1'b1);
        end
        u_pid_host.xfer(1'b1, `PID_CMD_MODEL, 8'h02, 48'hbeef, got);
        check({got.ack, cml}, 9'h0);
        rd_stores();
        $display("store write test done");
        for (int j = 0; j < 2; j++) begin
            u_pid_host.xfer(1'b1, ro_cmd[j], 8'h02, ~ro_val[j], got);
            check(got.ack, 1'b0);
            repeat (2) @(negedge i_core_clk);
            check({cml[7], stat[1], alert_n}, 3'b110);
            u_pid_host.xfer(1'b0, ro_cmd[j], 8'h00, 48'h0, got);
            check({got.ack, got.data & (j ? 48'hffff : '1)}, {1'b1, ro_val[j]});
            check(got.len, j ? 8'h02 : 8'h06);
            @(posedge i_core_clk);
            i_fault_clear <= 1'b1;
            @(posedge i_core_clk);
            i_fault_clear <= 1'b0;
            repeat (3) @(negedge i_core_clk);
            check({cml, alert_n}, 9'h1);
        end
        $display("read-only command test done");
        end_sim();
    end
endmodule
